// ===== design/ubr_pkg.sv
// package: register map, reset values, carriers and states of the uart block
`default_nettype none
package ubr_pkg;

  // ----------------------------------------
  // byte offsets
  // ----------------------------------------
  localparam logic [2:0] OFS_DATA  = 3'h0;
  localparam logic [2:0] OFS_DIVH  = 3'h1;
  localparam logic [2:0] OFS_LFMT  = 3'h3;
  localparam logic [2:0] OFS_MCTL  = 3'h4;
  localparam logic [2:0] OFS_LCOND = 3'h5;
  localparam logic [2:0] OFS_MSIG  = 3'h6;
  localparam logic [2:0] OFS_SCR   = 3'h7;

  // ----------------------------------------
  // fields, reset values, counts
  // ----------------------------------------
  localparam int         MC_DTR     = 0;
  localparam int         MC_RTS     = 1;
  localparam int         MC_LOOP    = 4;
  localparam int         SCR_NINTH  = 0;
  localparam logic [7:0] LFMT_RST   = 8'h03;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [15:0] DIV_RST   = 16'h0001;
  localparam logic [15:0] DIV_ONE   = 16'h0001;
  localparam logic [4:0] OS_NORMAL  = 5'h10;
  localparam logic [4:0] PRE_NORMAL = 5'h01;
  localparam logic [3:0] DATA_MIN   = 4'h5;
  localparam int         FIFO_DEPTH_DEF = 32;
  localparam int         FIFO_WIDTH = 9;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } ubr_state_e;

  typedef struct packed {
    logic       dlab;
    logic       brk;
    logic       force_par;
    logic       even;
    logic       par_en;
    logic       two_stop;
    logic [1:0] len;
  } ubr_lfmt_s;

  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } ubr_host_s;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ubr_modem_s;

endpackage : ubr_pkg
`default_nettype wire

// ===== design/ubr_fifo.sv
// file: transmit fifo with registered read data
`timescale 1ns/1ns
`default_nettype none
module ubr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,       // clock
  input  wire logic             rst_i,       // sync reset
  input  wire logic             in_valid_i,  // write request
  input  wire logic [WIDTH-1:0] in_data_i,   // write word
  output logic                  in_ready_o,  // room left
  output logic                  out_valid_o, // word waiting
  output logic      [WIDTH-1:0] out_data_o,  // registered word
  input  wire logic             out_ready_i, // word taken
  output logic                  empty_o      // nothing held
);
  // depth must be a power of two so the pointers wrap
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             load;

  assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
  assign push        = in_valid_i && in_ready_o;
  assign load        = (cnt_q != '0) && (!out_valid_o || out_ready_i);
  assign empty_o     = (cnt_q == '0) && !out_valid_o;

  always_ff @(posedge clk_i) begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_q + AW'(push);
      rd_q  <= rd_q + AW'(load);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end
    else if (load)
    begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_q[rd_q];
    end
    else if (out_ready_i)
    begin
      out_valid_o <= 1'b0;
    end
  end

endmodule : ubr_fifo
`default_nettype wire

// ===== design/ubr_uart_core.sv
// file: uart register file, baud generator and serial engine
//
// Overview of operation
// - offset 0 writes transmit byte, reads received byte while divisor access off
// - with divisor access on, offset 0 is the divisor low byte
// - with divisor access on, offset 1 is the divisor high byte
// - offset 3 holds length, stop, parity, odd/even, forced parity, break, divisor access
// - offset 7 is a scratch byte with no effect on the line outside nine-bit mode
// - nine-bit mode: offset 7 bit 0 sends ninth bit, offset 5 reports it
// - reference divided by divisor gives sample clock at sixteen times bit rate
// - enhanced clocking: samples per bit, prescaler and divisor set the rate
// - bit rate is reference over sample count, prescaler and divisor
`timescale 1ns/1ns
`default_nettype none
module ubr_uart_core
  import ubr_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic       ref_clk_i,      // 100 MHz reference
  input  wire logic       rst_i,          // sync reset, high
  input  wire ubr_host_s  host_i,         // host byte access
  output logic [7:0]      rdata_o,        // read data
  output logic            tx_ready_o,     // transmit buffer has room
  input  wire logic       nine_bit_i,     // nine-bit data mode
  input  wire logic       enh_clk_i,      // enhanced clocking mode
  input  wire logic [3:0] sample_count_i, // samples per bit, 0 = 16
  input  wire logic [4:0] prescale_i,     // prescaler, 0 = 1
  input  wire logic       rx_i,           // serial in
  input  wire ubr_modem_s modem_i,        // modem inputs
  output logic            tx_o,           // serial out
  output logic            rts_o,          // request to send
  output logic            dtr_o           // terminal ready
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  ubr_lfmt_s  lfmt_q;
  logic [15:0] div_q;
  logic [7:0]  mctl_q;
  logic [7:0]  scr_q;
  logic [7:0]  rd_mux;
  logic        rx_meta_q;
  logic        rx_sync_q;
  ubr_modem_s  modem_meta_q;
  ubr_modem_s  modem_sync_q;
  ubr_modem_s  modem_prev_q;
  logic [3:0]  delta_q;
  logic [3:0]  chg;
  logic        wr_txh;
  logic        rd_rxh;
  logic        rd_lcond;
  logic        rd_msig;
  logic [4:0]  os_w;
  logic [4:0]  os_half_w;
  logic [4:0]  pre_w;
  logic [15:0] div_w;
  logic [20:0] period_w;
  logic [20:0] pre_cnt_q;
  logic [4:0]  samp_cnt_q;
  logic        samp_tick;
  logic        bit_tick;
  logic [3:0]  nbits_w;
  logic        fifo_vld;
  logic [8:0]  fifo_dat;
  logic        fifo_empty;
  logic        tx_take;
  logic        tx_last;
  ubr_state_e  tx_st_q;
  logic [7:0]  tx_sh_q;
  logic        tx_ninth_q;
  logic        tx_par_q;
  logic [3:0]  tx_cnt_q;
  logic        tx_line_q;
  logic        par_bit;
  ubr_state_e  rx_st_q;
  logic [7:0]  rx_sh_q;
  logic [4:0]  rx_smp_q;
  logic [3:0]  rx_cnt_q;
  logic        rx_par_q;
  logic        rx_pbit_q;
  logic        rx_in;
  logic        rx_done;
  logic        rx_full;
  logic        rx_pe;
  logic        rx_fe;
  logic        rx_bi;
  logic        rx_exp;
  logic        rx_store;
  logic [7:0]  rx_data_q;
  logic        rx_ninth_q;
  logic        rx_valid_q;
  logic        ovr_q;
  logic        pe_q;
  logic        fe_q;
  logic        bi_q;
  logic        err_q;
  logic        txh_empty;
  logic        tx_empty;

  // ----------------------------------------
  // host decode and registers
  // ----------------------------------------
  assign wr_txh   = host_i.wr && host_i.addr == OFS_DATA && !lfmt_q.dlab;
  assign rd_rxh   = host_i.rd && host_i.addr == OFS_DATA && !lfmt_q.dlab;
  assign rd_lcond = host_i.rd && host_i.addr == OFS_LCOND;
  assign rd_msig  = host_i.rd && host_i.addr == OFS_MSIG;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
    begin
      lfmt_q <= LFMT_RST;
      div_q  <= DIV_RST;
      mctl_q <= BYTE_ZERO;
      scr_q  <= BYTE_ZERO;
    end
    else if (host_i.wr)
    begin
      case (host_i.addr)
        OFS_DATA:
          if (lfmt_q.dlab) div_q[7:0] <= host_i.wdata;
        OFS_DIVH:
          if (lfmt_q.dlab) div_q[15:8] <= host_i.wdata;
        OFS_LFMT: lfmt_q <= host_i.wdata;
        OFS_MCTL: mctl_q <= host_i.wdata;
        OFS_SCR:  scr_q  <= host_i.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (host_i.addr)
      OFS_DATA:  rd_mux = lfmt_q.dlab ? div_q[7:0] : rx_data_q;
      OFS_DIVH:  rd_mux = lfmt_q.dlab ? div_q[15:8] : BYTE_ZERO;
      OFS_LFMT:  rd_mux = lfmt_q;
      OFS_MCTL:  rd_mux = mctl_q;
      OFS_LCOND: rd_mux = {err_q & rx_valid_q, tx_empty, txh_empty, bi_q, fe_q,
                           nine_bit_i ? rx_ninth_q : pe_q, ovr_q, rx_valid_q};
      OFS_MSIG:  rd_mux = {modem_sync_q, delta_q};
      OFS_SCR:   rd_mux = scr_q;
      default:   rd_mux = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      rdata_o <= BYTE_ZERO;
    else if (host_i.rd)
      rdata_o <= rd_mux;
  end

  assign rts_o = mctl_q[MC_RTS];
  assign dtr_o = mctl_q[MC_DTR];

  // ----------------------------------------
  // pin synchronisers and modem flags
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
    begin
      rx_meta_q    <= 1'b1;
      rx_sync_q    <= 1'b1;
      modem_meta_q <= '0;
      modem_sync_q <= '0;
      modem_prev_q <= '0;
    end
    else
    begin
      rx_meta_q    <= rx_i;
      rx_sync_q    <= rx_meta_q;
      modem_meta_q <= modem_i;
      modem_sync_q <= modem_meta_q;
      modem_prev_q <= modem_sync_q;
    end
  end

  // ri flags only its trailing edge
  assign chg = {modem_sync_q.dcd ^ modem_prev_q.dcd,
                modem_prev_q.ri & ~modem_sync_q.ri,
                modem_sync_q.dsr ^ modem_prev_q.dsr,
                modem_sync_q.cts ^ modem_prev_q.cts};

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      delta_q <= '0;
    else
      delta_q <= chg | (delta_q & {4{~rd_msig}});
  end

  // ----------------------------------------
  // baud generator
  // ----------------------------------------
  assign os_w = (enh_clk_i && sample_count_i != '0) ? {1'b0, sample_count_i}
                                                    : OS_NORMAL;
  assign pre_w = (enh_clk_i && prescale_i != '0) ? prescale_i : PRE_NORMAL;
  assign div_w = (div_q == '0) ? DIV_ONE : div_q;
  assign period_w = {16'h0000, pre_w} * {5'h00, div_w};
  assign os_half_w = ((os_w >> 1) == '0) ? '0 : (os_w >> 1) - 5'h01;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      pre_cnt_q <= '0;
    else if (pre_cnt_q >= period_w - 21'h000001)
      pre_cnt_q <= '0;
    else
      pre_cnt_q <= pre_cnt_q + 21'h000001;
  end

  assign samp_tick = pre_cnt_q >= period_w - 21'h000001;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      samp_cnt_q <= '0;
    else if (samp_tick)
      samp_cnt_q <= (samp_cnt_q >= os_w - 5'h01) ? '0 : samp_cnt_q + 5'h01;
  end

  assign bit_tick = samp_tick && samp_cnt_q >= os_w - 5'h01;

  // ----------------------------------------
  // transmit buffer and transmitter
  // ----------------------------------------
  ubr_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i       (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_txh),
    .in_data_i   ({nine_bit_i & scr_q[SCR_NINTH], host_i.wdata}),
    .in_ready_o  (tx_ready_o),
    .out_valid_o (fifo_vld),
    .out_data_o  (fifo_dat),
    .out_ready_i (tx_take),
    .empty_o     (fifo_empty)
  );

  assign nbits_w   = DATA_MIN + {2'b00, lfmt_q.len};
  assign tx_last   = tx_st_q == ST_STOP && (!lfmt_q.two_stop || tx_cnt_q != '0);
  assign tx_take   = bit_tick && fifo_vld && (tx_st_q == ST_IDLE || tx_last);
  assign txh_empty = fifo_empty;
  assign tx_empty  = fifo_empty && (tx_st_q == ST_IDLE);
  assign par_bit   = nine_bit_i ? tx_ninth_q :
                     lfmt_q.force_par ? ~lfmt_q.even :
                     lfmt_q.even ? tx_par_q : ~tx_par_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
    begin
      tx_st_q    <= ST_IDLE;
      tx_sh_q    <= '0;
      tx_ninth_q <= 1'b0;
      tx_par_q   <= 1'b0;
      tx_cnt_q   <= '0;
      tx_line_q  <= 1'b1;
    end
    else if (tx_take)
    begin
      tx_st_q    <= ST_START;
      tx_sh_q    <= fifo_dat[7:0];
      tx_ninth_q <= fifo_dat[8];
      tx_line_q  <= 1'b0;
    end
    else if (bit_tick)
    begin
      case (tx_st_q)
        ST_IDLE: tx_line_q <= 1'b1;
        ST_START:
        begin
          tx_line_q <= tx_sh_q[0];
          tx_par_q  <= tx_sh_q[0];
          tx_sh_q   <= tx_sh_q >> 1;
          tx_cnt_q  <= '0;
          tx_st_q   <= ST_DATA;
        end
        ST_DATA:
          if (tx_cnt_q == nbits_w - 4'h1)
          begin
            tx_cnt_q <= '0;
            if (nine_bit_i || lfmt_q.par_en)
            begin
              tx_line_q <= par_bit;
              tx_st_q   <= ST_PAR;
            end
            else
            begin
              tx_line_q <= 1'b1;
              tx_st_q   <= ST_STOP;
            end
          end
          else
          begin
            tx_line_q <= tx_sh_q[0];
            tx_par_q  <= tx_par_q ^ tx_sh_q[0];
            tx_sh_q   <= tx_sh_q >> 1;
            tx_cnt_q  <= tx_cnt_q + 4'h1;
          end
        ST_PAR:
        begin
          tx_line_q <= 1'b1;
          tx_st_q   <= ST_STOP;
        end
        ST_STOP:
          if (tx_last)
            tx_st_q <= ST_IDLE;
          else
            tx_cnt_q <= tx_cnt_q + 4'h1;
        default: tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // loopback keeps the pin idle; break holds it low
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
      tx_o <= 1'b1;
    else
      tx_o <= (tx_line_q | mctl_q[MC_LOOP]) & ~lfmt_q.brk;
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign rx_in   = mctl_q[MC_LOOP] ? tx_line_q : rx_sync_q;
  assign rx_full = samp_tick && rx_smp_q >= os_w - 5'h01;
  assign rx_done = rx_full && rx_st_q == ST_STOP;
  assign rx_exp  = lfmt_q.force_par ? ~lfmt_q.even :
                   lfmt_q.even ? rx_par_q : ~rx_par_q;
  assign rx_pe   = lfmt_q.par_en && !nine_bit_i && rx_pbit_q != rx_exp;
  assign rx_fe   = !rx_in;
  assign rx_bi   = !rx_in && rx_sh_q == '0 && !rx_pbit_q;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
    begin
      rx_st_q   <= ST_IDLE;
      rx_sh_q   <= '0;
      rx_smp_q  <= '0;
      rx_cnt_q  <= '0;
      rx_par_q  <= 1'b0;
      rx_pbit_q <= 1'b0;
    end
    else if (samp_tick)
    begin
      rx_smp_q <= rx_full ? '0 : rx_smp_q + 5'h01;
      case (rx_st_q)
        ST_IDLE:
        begin
          rx_smp_q <= '0;
          if (!rx_in) rx_st_q <= ST_START;
        end
        ST_START:
          if (rx_smp_q >= os_half_w)
          begin
            rx_smp_q  <= '0;
            rx_sh_q   <= '0;
            rx_cnt_q  <= '0;
            rx_par_q  <= 1'b0;
            rx_pbit_q <= 1'b0;
            rx_st_q   <= rx_in ? ST_IDLE : ST_DATA;
          end
        ST_DATA:
          if (rx_full)
          begin
            rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_in;
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == nbits_w - 4'h1)
              rx_st_q <= (nine_bit_i || lfmt_q.par_en) ? ST_PAR : ST_STOP;
          end
        ST_PAR:
          if (rx_full)
          begin
            rx_pbit_q <= rx_in;
            rx_st_q   <= ST_STOP;
          end
        ST_STOP:
          if (rx_full) rx_st_q <= ST_IDLE;
        default: rx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receive holding and line status
  // ----------------------------------------
  // a byte is kept only if the holding slot is free or being read
  assign rx_store = rx_done && (!rx_valid_q || rd_rxh);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
    begin
      rx_data_q  <= '0;
      rx_ninth_q <= 1'b0;
      err_q      <= 1'b0;
    end
    else if (rx_store)
    begin
      rx_data_q  <= rx_sh_q >> (4'h8 - nbits_w);
      rx_ninth_q <= nine_bit_i & rx_pbit_q;
      err_q      <= rx_pe | rx_fe | rx_bi;
    end
  end

  // set wins over the read that clears
  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
    begin
      rx_valid_q <= 1'b0;
      ovr_q      <= 1'b0;
      pe_q       <= 1'b0;
      fe_q       <= 1'b0;
      bi_q       <= 1'b0;
    end
    else
    begin
      rx_valid_q <= rx_store | (rx_valid_q & ~rd_rxh);
      ovr_q      <= (rx_done & rx_valid_q & ~rd_rxh) | (ovr_q & ~rd_lcond);
      pe_q       <= (rx_store & rx_pe) | (pe_q & ~rd_lcond);
      fe_q       <= (rx_store & rx_fe) | (fe_q & ~rd_lcond);
      bi_q       <= (rx_store & rx_bi) | (bi_q & ~rd_lcond);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic [20:0] gap_q;
  logic [4:0]  bs_q;
  logic [20:0] per_q;
  logic [4:0]  os_q;
  logic        gap_ok_q;
  logic        cfg_chg;

  assign cfg_chg = per_q != period_w || os_q != os_w;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i)
    begin
      gap_q    <= '0;
      bs_q     <= '0;
      per_q    <= '0;
      os_q     <= '0;
      gap_ok_q <= 1'b0;
    end
    else
    begin
      gap_q    <= samp_tick ? '0 : gap_q + 21'h000001;
      bs_q     <= bit_tick ? '0 : bs_q + 5'(samp_tick);
      per_q    <= period_w;
      os_q     <= os_w;
      gap_ok_q <= (bit_tick | gap_ok_q) & ~cfg_chg;
    end
  end

  sequence s_lfmt_wr;
    host_i.wr && host_i.addr == OFS_LFMT;
  endsequence
  sequence s_lfmt_rd;
    host_i.rd && host_i.addr == OFS_LFMT && !host_i.wr;
  endsequence
  sequence s_scr_wr;
    host_i.wr && host_i.addr == OFS_SCR;
  endsequence
  sequence s_scr_rd;
    host_i.rd && host_i.addr == OFS_SCR && !host_i.wr;
  endsequence

  a_rxh_read : assert property (rd_rxh |=> rdata_o == $past(rx_data_q))
    else $error("receive byte not returned at offset 0");
  a_txh_push : assert property (wr_txh && tx_ready_o |=> !txh_empty)
    else $error("transmit write not buffered");
  a_divl_write : assert property (
    host_i.wr && host_i.addr == OFS_DATA && lfmt_q.dlab
      |=> div_q[7:0] == $past(host_i.wdata) && !$fell(txh_empty))
    else $error("divisor low byte not written");
  a_divh_write : assert property (
    host_i.wr && host_i.addr == OFS_DIVH && lfmt_q.dlab
      |=> div_q[15:8] == $past(host_i.wdata))
    else $error("divisor high byte not written");
  a_lfmt_back : assert property (
    s_lfmt_wr ##1 !host_i.wr ##1 s_lfmt_rd |=> rdata_o == $past(host_i.wdata, 3))
    else $error("line format readback differs");
  a_scratch_back : assert property (
    s_scr_wr ##1 !host_i.wr ##1 s_scr_rd |=> rdata_o == $past(host_i.wdata, 3))
    else $error("scratch readback differs");
  a_ninth_rx : assert property (
    rd_lcond && nine_bit_i |=> rdata_o[2] == $past(rx_ninth_q))
    else $error("ninth receive bit not reported");
  a_sample_gap : assert property (
    samp_tick && gap_ok_q && !cfg_chg |-> gap_q == period_w - 21'h000001)
    else $error("sample tick spacing wrong");
  a_bit_samples : assert property (
    bit_tick && gap_ok_q && !cfg_chg |-> bs_q == os_w - 5'h01)
    else $error("samples per bit wrong");
  a_overrun_set : assert property (
    rx_done && rx_valid_q && !rd_rxh |=> ovr_q && rx_valid_q)
    else $error("overrun not flagged");
  a_delta_cts : assert property (
    modem_sync_q.cts != modem_prev_q.cts |=> delta_q[0])
    else $error("cts change not flagged");

endmodule : ubr_uart_core
`default_nettype wire

// ===== test/ubr_serial_peer.sv
// model: remote serial device that sends frames and decodes the block's frames
`timescale 1ns/1ns
`default_nettype none
module ubr_serial_peer (
  input  wire logic clk_i,  // bench clock
  input  wire logic line_i, // block's serial output
  output logic      line_o  // block's serial input
);
  logic [8:0] got;     // last frame, nine bits after start
  int         bit_len; // measured start bit, clocks
  int         rx_cnt;  // frames decoded
  int         n;

  initial
  begin
    line_o = 1'b1;
    got = 9'h000;
    bit_len = 0;
    rx_cnt = 0;
  end

  // ----------------------------------------
  // decoder: start bit length paces the sampling
  // ----------------------------------------
  always
  begin
    @(negedge line_i);
    n = 0;
    @(negedge clk_i);
    while (line_i === 1'b0 && n < 5000)
    begin
      n++;
      @(negedge clk_i);
    end
    bit_len = n;
    repeat (n / 2) @(negedge clk_i);
    for (int i = 0; i < 9; i++)
    begin
      if (i > 0)
        repeat (n) @(negedge clk_i);
      got[i] = line_i;
    end
    rx_cnt++;
  end

  // ----------------------------------------
  // sender: start, nb bits lsb first, one stop, then idle high
  // ----------------------------------------
  task automatic send(input logic [8:0] d, input int nb, input int len);
    line_o = 1'b0;
    repeat (len) @(negedge clk_i);
    for (int b = 0; b < nb; b++)
    begin
      line_o = d[b];
      repeat (len) @(negedge clk_i);
    end
    line_o = 1'b1;
    repeat (len) @(negedge clk_i);
  endtask : send
endmodule : ubr_serial_peer
`default_nettype wire

// ===== test/tb.sv
// testbench: registers, rates, frames and transmit buffer of the uart block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ubr_pkg::*;
  logic       ref_clk_i;
  logic       rst_i;
  ubr_host_s  host;
  logic [7:0] rdata;
  logic       tx_ready;
  logic       nine_bit;
  logic       enh;
  logic [3:0] smp;
  logic [4:0] pre;
  ubr_modem_s modem;
  logic       tx;
  logic       rx;
  logic       rts;
  logic       dtr;
  logic [7:0] v;
  int         n_mismatch;
  int         checked;
  int         k;
  int         n0;
  int         e;
  int         cfg [4][4] = '{'{0, 0, 0, 2}, '{0, 0, 0, 3}, '{1, 4, 4, 1}, '{1, 4, 1, 2}};
  logic [7:0] fmt [4] = '{8'h15, 8'h2A, 8'hBF, 8'h03};

  ubr_uart_core dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .host_i(host), .rdata_o(rdata),
    .tx_ready_o(tx_ready), .nine_bit_i(nine_bit), .enh_clk_i(enh), .sample_count_i(smp),
    .prescale_i(pre), .rx_i(rx), .modem_i(modem), .tx_o(tx), .rts_o(rts), .dtr_o(dtr));
  ubr_serial_peer peer_u (.clk_i(ref_clk_i), .line_i(tx), .line_o(rx));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------
  // access and check tasks
  // ----------------------------------------
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    host = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge ref_clk_i);
    host.wr = 1'b0;
    @(negedge ref_clk_i);
  endtask : wr

  task automatic rd(input logic [2:0] a);
    host = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge ref_clk_i);
    host.rd = 1'b0;
    v = rdata;
    @(negedge ref_clk_i);
  endtask : rd

  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    rd(a);
    chk(v, exp);
  endtask : rc

  task automatic hang(input int got, input int exp);
    n_mismatch++;
    $display("unexpected at %0t: waited %h expected %h", $time, got, exp);
    wrap_up();
  endtask : hang

  task automatic poll(input logic [2:0] a, input int b);
    for (int i = 0; i < 300; i++)
    begin
      rd(a);
      if (v[b] === 1'b1)
        return;
    end
    hang(v, b);
  endtask : poll

  task automatic wait_peer(input int n, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      if (peer_u.rx_cnt >= n)
        return;
      @(negedge ref_clk_i);
    end
    hang(peer_u.rx_cnt, n);
  endtask : wait_peer

  task automatic set_div(input logic [15:0] d);
    wr(OFS_LFMT, 8'h80);
    wr(OFS_DATA, d[7:0]);
    wr(OFS_DIVH, d[15:8]);
    wr(OFS_LFMT, 8'h03);
  endtask : set_div

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic wrap_up;
    $display("counts: checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    n_mismatch = 0;
    checked = 0;
    rst_i = 1'b1;
    host = '0;
    nine_bit = 1'b0;
    enh = 1'b0;
    smp = 4'h0;
    pre = 5'h00;
    modem = '0;
    repeat (12) @(negedge ref_clk_i);
    rst_i = 1'b0;
    rc(OFS_LFMT, 8'h03);
    rc(OFS_MSIG, 8'h00);
    foreach (fmt[i])
    begin
      wr(OFS_LFMT, fmt[i]);
      rc(OFS_LFMT, fmt[i]);
    end
    // none of the formats above sets break, so the line stays idle; wait before the divisor checks
    repeat (100) @(negedge ref_clk_i);
    wr(OFS_LFMT, 8'h80);
    wr(OFS_DATA, 8'h5A);
    wr(OFS_DIVH, 8'hC3);
    rc(OFS_DATA, 8'h5A);
    rc(OFS_DIVH, 8'hC3);
    wr(OFS_LFMT, 8'h03);
    rc(OFS_DIVH, 8'h00);
    rc(OFS_DATA, 8'h00);
    wr(OFS_SCR, 8'hA5);
    rc(OFS_SCR, 8'hA5);
    done("registers");
    for (int j = 0; j < 4; j++)
    begin
      poll(OFS_LCOND, 6);
      enh = cfg[j][0][0];
      smp = cfg[j][1][3:0];
      pre = cfg[j][2][4:0];
      set_div(cfg[j][3][15:0]);
      e = (cfg[j][0] != 0) ? cfg[j][1] * cfg[j][2] * cfg[j][3] : 16 * cfg[j][3];
      n0 = peer_u.rx_cnt;
      wr(OFS_DATA, 8'hA5);
      wait_peer(n0 + 1, 2000);
      chk(peer_u.got, 9'h1A5);
      chk(9'(peer_u.bit_len), 9'(e));
    end
    poll(OFS_LCOND, 6);
    enh = 1'b0;
    set_div(16'h0001);
    done("rates");
    peer_u.send(9'h03C, 8, 16);
    poll(OFS_LCOND, 0);
    chk(v, 9'h061);
    rc(OFS_DATA, 8'h3C);
    rc(OFS_LCOND, 8'h60);
    nine_bit = 1'b1;
    wr(OFS_SCR, 8'h00);
    n0 = peer_u.rx_cnt;
    wr(OFS_DATA, 8'hA5);
    wait_peer(n0 + 1, 400);
    chk(peer_u.got, 9'h0A5);
    peer_u.send(9'h1C3, 9, 16);
    poll(OFS_LCOND, 0);
    chk(v[2], 9'h001);
    rc(OFS_DATA, 8'hC3);
    nine_bit = 1'b0;
    // second byte arrives while the first is still held
    peer_u.send(9'h011, 8, 16);
    peer_u.send(9'h022, 8, 16);
    rc(OFS_LCOND, 8'h63);
    rc(OFS_DATA, 8'h11);
    rc(OFS_LCOND, 8'h60);
    done("receive");
    modem.cts = 1'b1;
    modem.ri = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    rc(OFS_MSIG, 8'h51);
    rc(OFS_MSIG, 8'h50);
    modem = '{dcd: 1'b1, ri: 1'b0, dsr: 1'b0, cts: 1'b1};
    repeat (6) @(negedge ref_clk_i);
    rc(OFS_MSIG, 8'h9C);
    wr(OFS_MCTL, 8'h13);
    chk({rts, dtr}, 9'h003);
    // loopback: the byte returns internally and the pin stays idle
    n0 = peer_u.rx_cnt;
    wr(OFS_DATA, 8'h96);
    poll(OFS_LCOND, 0);
    rc(OFS_DATA, 8'h96);
    chk(9'(peer_u.rx_cnt - n0), 9'h000);
    wr(OFS_MCTL, 8'h00);
    done("modem");
    n0 = peer_u.rx_cnt;
    for (k = 0; k < 40 && tx_ready === 1'b1; k++)
      wr(OFS_DATA, {k[6:0], 1'b1});
    chk(9'(k >= 32 && k <= 34), 9'h001);
    wr(OFS_DATA, 8'h00);
    e = k - 1;
    wait_peer(n0 + k, 8000);
    chk(peer_u.got, {1'b1, e[6:0], 1'b1});
    poll(OFS_LCOND, 6);
    chk(tx_ready, 9'h001);
    chk(9'(peer_u.rx_cnt - n0), 9'(k));
    done("buffer");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
